// ---- common/ssr_defs.svh ----
// Register offsets, field positions, reset values and rates of the synchronous serial receiver.
`ifndef SSR_DEFS_SVH
`define SSR_DEFS_SVH

`define SSR_ADDR_W 16
`define SSR_OFF_CTRL 16'hFFA0
`define SSR_OFF_STAT 16'hFFA1
`define SSR_OFF_SERIAL_DATA_UPPER 16'hFFA2
`define SSR_OFF_SERIAL_DATA_LOW 16'hFFA3
`define SSR_OFF_IEN 16'hFFF5
`define SSR_OFF_IRR 16'hFFF8
`define SSR_OFF_PMR 16'hFFFD

`define SSR_RST_VAL 8'h00

`define SSR_CTRL_MODE_HI 7
`define SSR_CTRL_MODE_LO 6
`define SSR_CTRL_MARK 5
`define SSR_CTRL_LATCH 4
`define SSR_CTRL_EXT 3
`define SSR_CTRL_CKS_HI 2
`define SSR_CTRL_CKS_LO 0

`define SSR_STAT_OVR 5
`define SSR_STAT_MARKF 1
`define SSR_STAT_START 0

`define SSR_IRQ_BIT 4

`define SSR_PMR_SO 2
`define SSR_PMR_SI 1
`define SSR_PMR_SCK 0

`define SSR_MODE_8 2'h0
`define SSR_MODE_16 2'h1
`define SSR_MODE_CONT 2'h2
`define SSR_MODE_12 2'h3

`define SSR_LEN_8 5'h08
`define SSR_LEN_12 5'h0C
`define SSR_LEN_16 5'h10

`define SSR_PRE_BASE 2
`define SSR_PRE_CNT_W 12

`endif

// ---- common/ssr_pkg.sv ----
// Types shared by the synchronous serial receiver modules.
`default_nettype none
`include "ssr_defs.svh"

package ssr_pkg;

    typedef enum logic {
        SSR_IDLE,
        SSR_SHIFT
    } ssr_state_t;

    typedef struct packed {
        logic [`SSR_ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ssr_bus_t;

endpackage : ssr_pkg

`default_nettype wire

// ---- verilog/ssr_prescaler.sv ----
// Internal transfer clock divider giving one-cycle edge enables.
`timescale 1ns/1ps
`default_nettype none
`include "ssr_defs.svh"

module ssr_prescaler
#(
    parameter int PRE_BASE = `SSR_PRE_BASE,
    parameter int CNT_W = `SSR_PRE_CNT_W
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic run,
    input wire logic [2:0] sel,
    output logic rise_en,
    output logic fall_en
);

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] half;
    logic phase_r;

    // Half period doubles with each of the eight rate selections.
    assign half = CNT_W'(PRE_BASE) << sel;

    // Stopping restarts the phase high, so every run opens with a falling edge.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= '0;
            phase_r <= 1'b1;
            rise_en <= 1'b0;
            fall_en <= 1'b0;
        end else if (!run) begin
            cnt_r <= '0;
            phase_r <= 1'b1;
            rise_en <= 1'b0;
            fall_en <= 1'b0;
        end else if (cnt_r == CNT_W'(half - 1'b1)) begin
            cnt_r <= '0;
            phase_r <= !phase_r;
            fall_en <= phase_r;
            rise_en <= !phase_r;
        end else begin
            cnt_r <= CNT_W'(cnt_r + 1'b1);
            rise_en <= 1'b0;
            fall_en <= 1'b0;
        end
    end

endmodule : ssr_prescaler

`default_nettype wire

// ---- verilog/ssr_top.sv ----
// Synchronous serial receive and transmit unit with its registers and pin switches.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "ssr_defs.svh"

module ssr_top
    import ssr_pkg::*;
#(
    parameter int PRE_BASE = `SSR_PRE_BASE,
    parameter int PRE_CNT_W = `SSR_PRE_CNT_W
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire ssr_bus_t bus,
    output logic [7:0] rdata,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    input wire logic si_in,
    output logic so_out,
    output logic so_oe,
    output logic irq
);

    function automatic logic wr_hit(input ssr_bus_t b, input logic [`SSR_ADDR_W-1:0] off);
        wr_hit = b.wr && (b.addr == off);
    endfunction : wr_hit

    function automatic logic [4:0] word_len(input logic [1:0] mode);
        if (mode == `SSR_MODE_16) begin
            word_len = `SSR_LEN_16;
        end else if (mode == `SSR_MODE_12) begin
            word_len = `SSR_LEN_12;
        end else begin
            word_len = `SSR_LEN_8;
        end
    endfunction : word_len

    ssr_state_t state_r;
    logic [7:0] ctrl_r;
    logic [7:0] ien_r;
    logic [7:0] pmr_r;
    logic [7:0] serial_data_upper_r;
    logic [7:0] serial_data_low_r;
    logic [4:0] cnt_r;
    logic start_r;
    logic ovr_r;
    logic irq_flag_r;
    logic done_r;
    logic sck_prev_r;
    logic sck_out_r;
    logic sck_oe_r;
    logic so_r;
    logic so_oe_r;
    logic irq_r;
    logic [7:0] rdata_r;

    logic [1:0] mode;
    logic ext_clk;
    logic cont_mode;
    logic int_run;
    logic int_rise;
    logic int_fall;
    logic ext_rise;
    logic ext_fall;
    logic rise;
    logic fall;
    logic si_bit;
    logic start_req;
    logic done_evt;
    logic ovr_evt;
    logic ctrl_wr;
    logic stat_wr;
    logic serial_data_upper_wr;
    logic serial_data_low_wr;
    logic ien_wr;
    logic irr_wr;
    logic pmr_wr;
    logic ovr_clr;
    logic irq_clr;
    logic [7:0] stat_word;

    assign mode = {ctrl_r[`SSR_CTRL_MODE_HI], ctrl_r[`SSR_CTRL_MODE_LO]};
    assign ext_clk = ctrl_r[`SSR_CTRL_EXT];
    assign cont_mode = (mode == `SSR_MODE_CONT) && !ext_clk;

    // Each register is decoded once, so the write and clear paths cannot disagree.
    assign ctrl_wr = wr_hit(bus, `SSR_OFF_CTRL);
    assign stat_wr = wr_hit(bus, `SSR_OFF_STAT);
    assign serial_data_upper_wr = wr_hit(bus, `SSR_OFF_SERIAL_DATA_UPPER);
    assign serial_data_low_wr = wr_hit(bus, `SSR_OFF_SERIAL_DATA_LOW);
    assign ien_wr = wr_hit(bus, `SSR_OFF_IEN);
    assign irr_wr = wr_hit(bus, `SSR_OFF_IRR);
    assign pmr_wr = wr_hit(bus, `SSR_OFF_PMR);
    assign ovr_clr = stat_wr && bus.wdata[`SSR_STAT_OVR];
    assign irq_clr = irr_wr && bus.wdata[`SSR_IRQ_BIT];
    // Tail mark and unused status bits read zero; no tail mark is ever sent.
    assign stat_word = 8'(({7'h00, ovr_r} << `SSR_STAT_OVR)
        | ({7'h00, start_r} << `SSR_STAT_START));

    // The divider runs for an internally clocked transfer, or all the time in continuous mode.
    assign int_run = !ext_clk && ((state_r == SSR_SHIFT) || cont_mode);

    ssr_prescaler #(
        .PRE_BASE(PRE_BASE),
        .CNT_W(PRE_CNT_W)
    ) u_prescaler (
        .clk(clk),
        .rstn(rstn),
        .run(int_run),
        .sel(ctrl_r[`SSR_CTRL_CKS_HI:`SSR_CTRL_CKS_LO]),
        .rise_en(int_rise),
        .fall_en(int_fall)
    );

    // The pin is taken as synchronous, so one register suffices for edge detection.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sck_prev_r <= 1'b1;
        end else begin
            sck_prev_r <= sck_in;
        end
    end

    assign ext_rise = ext_clk && pmr_r[`SSR_PMR_SCK] && sck_in && !sck_prev_r;
    assign ext_fall = ext_clk && pmr_r[`SSR_PMR_SCK] && !sck_in && sck_prev_r;
    assign rise = ext_clk ? ext_rise : int_rise;
    assign fall = ext_clk ? ext_fall : int_fall;

    // Without the pin function the input reads as an idle high line.
    assign si_bit = pmr_r[`SSR_PMR_SI] ? si_in : 1'b1;

    assign start_req = stat_wr && bus.wdata[`SSR_STAT_START]
        && (state_r == SSR_IDLE) && !cont_mode;
    assign done_evt = (state_r == SSR_SHIFT) && rise
        && (cnt_r == 5'(word_len(mode) - 1'b1));
    assign ovr_evt = (state_r == SSR_IDLE) && done_r && rise && !cont_mode;

    // Transfer sequencing: start, edge count and completion.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= SSR_IDLE;
            cnt_r <= '0;
        end else if (start_req) begin
            state_r <= SSR_SHIFT;
            cnt_r <= '0;
        end else begin
            case (state_r)
                SSR_IDLE: begin
                    cnt_r <= '0;
                end
                SSR_SHIFT: begin
                    if (done_evt) begin
                        state_r <= SSR_IDLE;
                    end else if (rise) begin
                        cnt_r <= 5'(cnt_r + 1'b1);
                    end
                end
                default: begin
                    state_r <= SSR_IDLE;
                end
            endcase
        end
    end

    // Start flag doubles as busy status: set by the start write, dropped at completion.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            start_r <= 1'b0;
        end else if (start_req) begin
            start_r <= 1'b1;
        end else if (done_evt) begin
            start_r <= 1'b0;
        end
    end

    // Remembers a finished word; only then do stray edges count as overrun.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            done_r <= 1'b0;
        end else if (start_req) begin
            done_r <= 1'b0;
        end else if (done_evt) begin
            done_r <= 1'b1;
        end
    end

    // Control, enable and port mode registers.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_r <= `SSR_RST_VAL;
            ien_r <= `SSR_RST_VAL;
            pmr_r <= `SSR_RST_VAL;
        end else begin
            if (ctrl_wr) begin
                ctrl_r <= bus.wdata;
            end
            if (ien_wr) begin
                ien_r <= bus.wdata;
            end
            if (pmr_wr) begin
                pmr_r <= bus.wdata;
            end
        end
    end

    // Shift register; contents read mid-transfer are not stable.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            serial_data_upper_r <= `SSR_RST_VAL;
            serial_data_low_r <= `SSR_RST_VAL;
        end else if ((state_r == SSR_SHIFT) && rise) begin
            serial_data_low_r <= {(mode == `SSR_MODE_8) ? si_bit : serial_data_upper_r[0], serial_data_low_r[7:1]};
            if (mode == `SSR_MODE_12) begin
                serial_data_upper_r <= {serial_data_upper_r[7:4], si_bit, serial_data_upper_r[3:1]};
            end else if (mode == `SSR_MODE_16) begin
                serial_data_upper_r <= {si_bit, serial_data_upper_r[7:1]};
            end
        end else begin
            if (serial_data_upper_wr) begin
                serial_data_upper_r <= bus.wdata;
            end
            if (serial_data_low_wr) begin
                serial_data_low_r <= bus.wdata;
            end
        end
    end

    // Overrun: a new edge wins over a clear in the same cycle.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ovr_r <= 1'b0;
        end else if (ovr_evt) begin
            ovr_r <= 1'b1;
        end else if (ovr_clr) begin
            ovr_r <= 1'b0;
        end
    end

    // Completion request flag, sticky until software writes a one to it.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_flag_r <= 1'b0;
        end else if (done_evt) begin
            irq_flag_r <= 1'b1;
        end else if (irq_clr) begin
            irq_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= irq_flag_r && ien_r[`SSR_IRQ_BIT];
        end
    end

    // Clock pin: the line idles high so each word opens on a falling edge.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sck_out_r <= 1'b1;
            sck_oe_r <= 1'b0;
        end else begin
            sck_oe_r <= !ext_clk && pmr_r[`SSR_PMR_SCK];
            if (!int_run) begin
                sck_out_r <= 1'b1;
            end else if (int_fall) begin
                sck_out_r <= 1'b0;
            end else if (int_rise) begin
                sck_out_r <= 1'b1;
            end
        end
    end

    // Transmit bit moves on the falling edge and holds through the rising one.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            so_r <= 1'b1;
            so_oe_r <= 1'b0;
        end else begin
            so_oe_r <= pmr_r[`SSR_PMR_SO];
            if ((state_r == SSR_SHIFT) && fall) begin
                so_r <= serial_data_low_r[0];
            end
        end
    end

    // Register read port; data appear one cycle after the strobe, unmapped reads zero.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= `SSR_RST_VAL;
        end else if (!bus.rd) begin
            rdata_r <= `SSR_RST_VAL;
        end else if (bus.addr == `SSR_OFF_CTRL) begin
            rdata_r <= ctrl_r;
        end else if (bus.addr == `SSR_OFF_STAT) begin
            rdata_r <= stat_word;
        end else if (bus.addr == `SSR_OFF_SERIAL_DATA_UPPER) begin
            rdata_r <= serial_data_upper_r;
        end else if (bus.addr == `SSR_OFF_SERIAL_DATA_LOW) begin
            rdata_r <= serial_data_low_r;
        end else if (bus.addr == `SSR_OFF_IEN) begin
            rdata_r <= ien_r;
        end else if (bus.addr == `SSR_OFF_IRR) begin
            rdata_r <= 8'({7'h00, irq_flag_r} << `SSR_IRQ_BIT);
        end else if (bus.addr == `SSR_OFF_PMR) begin
            rdata_r <= pmr_r;
        end else begin
            rdata_r <= `SSR_RST_VAL;
        end
    end

    assign rdata = rdata_r;
    assign sck_out = sck_out_r;
    assign sck_oe = sck_oe_r;
    assign so_out = so_r;
    assign so_oe = so_oe_r;
    assign irq = irq_r;

endmodule : ssr_top

`default_nettype wire

// ---- tb/ssr_assertions.sv ----
// Port-level checks for the serial unit.
`timescale 1ns/1ps
`default_nettype none
`include "ssr_defs.svh"
module ssr_assertions
    import ssr_pkg::*;
#(
    parameter int PRE_BASE = 2,
    parameter int PRE_CNT_W = 12
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire ssr_bus_t bus,
    input wire logic [7:0] rdata,
    input wire logic sck_out,
    input wire logic sck_oe,
    input wire logic so_out,
    input wire logic so_oe,
    input wire logic irq
);
    logic [7:0] c_r;
    logic [7:0] p_r;
    logic [7:0] e_r;
    logic sck_r;
    logic [PRE_CNT_W:0] run_r;
    logic cont;
    assign cont = c_r[7:6] == 2'h2 && !c_r[3] && p_r[0];
    // Shadows of what software last wrote, so pin rules can be tied to their cause.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            c_r <= 8'h00;
            p_r <= 8'h00;
            e_r <= 8'h00;
        end else if (bus.wr) begin
            c_r <= bus.addr == `SSR_OFF_CTRL ? bus.wdata : c_r;
            p_r <= bus.addr == `SSR_OFF_PMR ? bus.wdata : p_r;
            e_r <= bus.addr == `SSR_OFF_IEN ? bus.wdata : e_r;
        end
    end
    // A stalled divider would pass a short check, so the quiet time is counted.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sck_r <= 1'b1;
            run_r <= '0;
        end else begin
            sck_r <= sck_out;
            run_r <= (!cont || sck_out != sck_r) ? '0 : run_r + 1'b1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence start_int;
        bus.wr && bus.addr == `SSR_OFF_STAT && bus.wdata[0] && !c_r[3] && p_r[0] && c_r[7:6] != 2'h2;
    endsequence
    sequence mask_off;
        bus.wr && bus.addr == `SSR_OFF_IEN && !bus.wdata[4];
    endsequence
    rdata_idle_a: assert property (!$past(bus.rd) |-> rdata == 8'h00)
        else $error("read data not zero outside a read");
    sck_dir_a: assert property (c_r == $past(c_r) && p_r == $past(p_r) |-> sck_oe == (p_r[0] && !c_r[3]))
        else $error("clock pin direction wrong");
    so_dir_a: assert property (p_r == $past(p_r) |-> so_oe == p_r[2])
        else $error("data pin enable wrong");
    cont_clock_a: assert property (run_r < (PRE_BASE << 7) + 4)
        else $error("continuous clock stopped");
    start_clock_a: assert property (start_int |-> ##[1:600] $fell(sck_out))
        else $error("start gave no clock");
    so_hold_a: assert property (sck_oe && $rose(sck_out) |-> $stable(so_out))
        else $error("data moved at rising edge");
    irq_mask_a: assert property (mask_off |-> ##2 !irq)
        else $error("masked interrupt still high");
    irq_cause_a: assert property ($rose(irq) |-> $past(e_r[4]))
        else $error("interrupt without enable");
endmodule : ssr_assertions
bind ssr_top ssr_assertions #(.PRE_BASE(PRE_BASE), .PRE_CNT_W(PRE_CNT_W)) ssr_assertions_i (
    .clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata), .sck_out(sck_out), .sck_oe(sck_oe),
    .so_out(so_out), .so_oe(so_oe), .irq(irq));
`default_nettype wire

// ---- tb/ssr_partner.sv ----
// External serial device that drives the clock and data lines.
`timescale 1ns/1ps
`default_nettype none
module ssr_partner
(
    input wire logic clk,
    output logic sck,
    output logic si,
    input wire logic so
);
    logic [15:0] got;
    initial begin
        sck = 1'b1;
        si = 1'b1;
        got = 16'h0000;
    end
    // Half periods of four clocks keep each edge visible to the synchronous detector.
    task automatic frame(input logic [15:0] d, input int n);
        for (int i = 0; i < n; i++) begin
            repeat (4) @(posedge clk);
            sck <= 1'b0;
            si <= d[i];
            repeat (4) @(posedge clk);
            sck <= 1'b1;
            got <= {so, got[15:1]};
        end
        repeat (4) @(posedge clk);
        si <= ~si;
    endtask : frame
endmodule : ssr_partner
`default_nettype wire

// ---- tb/ssr_bench.sv ----
// Self-checking bench for the serial unit.
`timescale 1ns/1ps
`default_nettype none
`include "ssr_defs.svh"
module ssr_bench
    import ssr_pkg::*;
;
    logic clk;
    logic rstn;
    ssr_bus_t bus;
    logic [7:0] rdata;
    logic sck_out, sck_oe, so_out, so_oe, irq, p_sck, p_si, loop, sq;
    int err_total = 0;
    int check_count = 0;
    int fcnt = 0;
    ssr_top ssr_top_i (.clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata), .sck_in(sck_oe ? sck_out : p_sck),
        .sck_out(sck_out), .sck_oe(sck_oe), .si_in(loop ? so_out : p_si), .so_out(so_out), .so_oe(so_oe), .irq(irq));
    ssr_partner ssr_partner_i (.clk(clk), .sck(p_sck), .si(p_si), .so(so_out));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        sq <= sck_out;
        if (sck_oe && sq && !sck_out) begin
            fcnt <= fcnt + 1;
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [7:0] v);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        @(posedge clk);
        v = rdata;
    endtask : rd
    task automatic rchk(input logic [15:0] a, input logic [7:0] e);
        logic [7:0] v;
        rd(a, v);
        chk({8'h00, v}, {8'h00, e});
    endtask : rchk
    task automatic t_regs();
        logic [15:0] offs [7] = '{16'hFFA0, 16'hFFA1, 16'hFFA2, 16'hFFA3, 16'hFFF5, 16'hFFF8, 16'hFFFD};
        foreach (offs[i]) begin
            rchk(offs[i], `SSR_RST_VAL);
        end
        wr(`SSR_OFF_CTRL, 8'h17);
        rchk(`SSR_OFF_CTRL, 8'h17);
        wr(`SSR_OFF_STAT, 8'hDE);
        rchk(`SSR_OFF_STAT, 8'h00);
        rchk(16'hFF00, 8'h00);
        $display("test regs done");
    endtask : t_regs
    task automatic t_ext();
        wr(`SSR_OFF_CTRL, 8'h08);
        wr(`SSR_OFF_PMR, 8'h07);
        wr(`SSR_OFF_IEN, 8'h10);
        wr(`SSR_OFF_SERIAL_DATA_LOW, 8'hA5);
        wr(`SSR_OFF_STAT, 8'h01);
        rchk(`SSR_OFF_STAT, 8'h01);
        ssr_partner_i.frame(16'h003C, 8);
        rchk(`SSR_OFF_STAT, 8'h00);
        chk({15'h0, irq}, 16'h0001);
        rchk(`SSR_OFF_SERIAL_DATA_LOW, 8'h3C);
        chk({ssr_partner_i.got[15:8], 7'h0, so_oe}, 16'hA501);
        $display("test external done");
    endtask : t_ext
    task automatic t_ovr();
        ssr_partner_i.frame(16'h00FF, 2);
        rchk(`SSR_OFF_STAT, 8'h20);
        rchk(`SSR_OFF_SERIAL_DATA_LOW, 8'h3C);
        wr(`SSR_OFF_STAT, 8'h20);
        rchk(`SSR_OFF_STAT, 8'h00);
        wr(`SSR_OFF_IRR, 8'h10);
        rchk(`SSR_OFF_IRR, 8'h00);
        $display("test overrun done");
    endtask : t_ovr
    task automatic t_mask();
        wr(`SSR_OFF_IEN, 8'h00);
        wr(`SSR_OFF_STAT, 8'h01);
        ssr_partner_i.frame(16'h0081, 8);
        chk({15'h0, irq}, 16'h0000);
        rchk(`SSR_OFF_IRR, 8'h10);
        rchk(`SSR_OFF_SERIAL_DATA_LOW, 8'h81);
        wr(`SSR_OFF_IEN, 8'h10);
        @(posedge clk);
        chk({15'h0, irq}, 16'h0001);
        wr(`SSR_OFF_IRR, 8'h10);
        @(posedge clk);
        chk({15'h0, irq}, 16'h0000);
        $display("test mask done");
    endtask : t_mask
    task automatic t_loop();
        logic [7:0] ctl [3] = '{8'h00, 8'h40, 8'hC0};
        int n [3] = '{8, 16, 12};
        logic [7:0] v;
        logic [7:0] m;
        int f0;
        loop <= 1'b1;
        foreach (ctl[i]) begin
            wr(`SSR_OFF_CTRL, ctl[i]);
            wr(`SSR_OFF_SERIAL_DATA_UPPER, 8'h12);
            wr(`SSR_OFF_SERIAL_DATA_LOW, 8'h34);
            f0 = fcnt;
            wr(`SSR_OFF_STAT, 8'h01);
            v = 8'h01;
            for (int k = 0; k < 300 && v[0]; k++) begin
                rd(`SSR_OFF_STAT, v);
            end
            chk(16'(fcnt - f0), n[i][15:0]);
            rchk(`SSR_OFF_SERIAL_DATA_LOW, 8'h34);
            m = n[i] == 12 ? 8'h0F : 8'hFF;
            rd(`SSR_OFF_SERIAL_DATA_UPPER, v);
            chk({8'h00, v & m}, {8'h00, 8'h12 & m});
        end
        wr(`SSR_OFF_PMR, 8'h05);
        wr(`SSR_OFF_STAT, 8'h01);
        repeat (80) @(posedge clk);
        rchk(`SSR_OFF_STAT, 8'h00);
        rchk(`SSR_OFF_SERIAL_DATA_LOW, 8'hFF);
        wr(`SSR_OFF_PMR, 8'h07);
        loop <= 1'b0;
        wr(`SSR_OFF_IRR, 8'h10);
        $display("test internal done");
    endtask : t_loop
    task automatic t_cont();
        int f0;
        wr(`SSR_OFF_CTRL, 8'h80);
        f0 = fcnt;
        repeat (64) @(posedge clk);
        chk(16'(fcnt - f0), 16'(64 / (2 * `SSR_PRE_BASE)));
        wr(`SSR_OFF_STAT, 8'h01);
        rchk(`SSR_OFF_STAT, 8'h00);
        wr(`SSR_OFF_CTRL, 8'h00);
        $display("test continuous done");
    endtask : t_cont
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        stop_test();
    end
    initial begin
        rstn = 1'b0;
        bus = '0;
        loop = 1'b0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_regs();
        t_ext();
        t_ovr();
        t_mask();
        t_loop();
        t_cont();
        stop_test();
    end
endmodule : ssr_bench
`default_nettype wire
